// file: include/swo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface swo_if;
   logic       ref_clk_primary;
   logic       ref_clk_secondary;
   logic       pll_locked;
   logic       switch_trig;
   logic       auto_en;
   logic [4:0] delay_sel;
   logic       primary_bad_flag;
   logic       secondary_bad_flag;
   logic       switch_cond;
   logic       active_clk;
   logic       pll_ref_clk;
   logic       pll_areset;
   logic       pfd_enable;
   logic       out_clk_en;
   modport device (
      input  ref_clk_primary, ref_clk_secondary, pll_locked,
      input  switch_trig, auto_en, delay_sel,
      output primary_bad_flag, secondary_bad_flag, switch_cond, active_clk, pll_ref_clk
   );
   modport user (
      input  pll_locked, primary_bad_flag, secondary_bad_flag, switch_cond, active_clk,
      output switch_trig, auto_en, delay_sel, pll_areset, pfd_enable, out_clk_en
   );
endinterface : swo_if
`default_nettype wire

// file: include/swo_pkg.sv
// Operation
// - Two reference clocks feed switchover mux.
// - Flag primary bad when it stops.
// - Flag secondary bad when it stops.
// - Manual mode: switch level selects clock.
// - Auto mode: switch input triggers switchover.
// - Drive switch-condition flag on switch cause.
// - Lost lock is a switchover cause.
// - Active clock output: 0 primary, 1 secondary.
// - Status outputs absent in manual-only mode.
// - Hold trigger high long enough.
// - Auto switch and manual trigger coexist.
// - Only trigger rising edge starts switchover.
// - Programmable delay up to 31 reference cycles.
// - Pulse PLL reset 10 ns after switchover; code pulses for one 40 ns cycle, on auto-mode switches only.
// - Drop phase-detector enable on clock bad.
// - Gate output clocks until lock stable.
// - Edge counters; count three flags other bad.
// - Gate mux on old falling edge first.
package swo_pkg;
   // Edge counter
   localparam int unsigned EDGE_BAD_CNT = 3;
   localparam int unsigned DLY_W        = 5;
   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned ARESET_NS      = 10;
   localparam int unsigned ARESET_CYC_RAW = (ARESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ARESET_CYC     = (ARESET_CYC_RAW < 1) ? 1 : ARESET_CYC_RAW;
   localparam int unsigned LOCK_STABLE_CYC = 16;
   localparam int unsigned TRIG_MAX_CYC    = 255;
   // Register offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CMD_OFS    = 8'h04;
   localparam logic [7:0] STAT_OFS   = 8'h08;
   localparam logic [7:0] IRQ_S_OFS  = 8'h0c;
   localparam logic [7:0] IRQ_M_OFS  = 8'h10;
   // CTRL fields
   localparam int unsigned CTRL_AUTO   = 0;
   localparam int unsigned CTRL_MSEL   = 1;
   localparam int unsigned CTRL_PFDH   = 2;
   localparam int unsigned CTRL_RSTSW  = 3;
   localparam int unsigned CTRL_DLY_LO = 8;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   // CMD fields
   localparam int unsigned CMD_TRIG = 0;
   localparam int unsigned CMD_RST  = 1;
   // STAT and IRQ fields
   localparam int unsigned EV_BAD0   = 0;
   localparam int unsigned EV_BAD1   = 1;
   localparam int unsigned EV_COND   = 2;
   localparam int unsigned EV_ACT    = 3;
   localparam int unsigned EV_UNLOCK = 4;
   localparam int unsigned EV_W      = 5;
   typedef enum logic [1:0] {SW_IDLE, SW_DELAY, SW_GATE, SW_SWAP} sw_state_t;
endpackage : swo_pkg

// file: rtl/swo_device.sv
`timescale 1ns/1ps
`default_nettype none
module swo_device (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   // Link
   swo_if.device     lnk
);
   // Sampled pins, one stage for edge detection
   logic p_q_ff;
   logic s_q_ff;
   logic trig_q_ff;
   logic lock_q_ff;

   // Edge counters and flags
   logic [1:0] cnt0_ff;
   logic [1:0] cnt1_ff;
   logic [1:0] nxt_cnt0;
   logic [1:0] nxt_cnt1;
   logic       bad0_ff;
   logic       bad1_ff;
   logic       nxt_bad0;
   logic       nxt_bad1;

   // Switch sequencer
   swo_pkg::sw_state_t state_ff;
   swo_pkg::sw_state_t nxt_state;
   logic             sel_ff;
   logic             nxt_sel;
   logic             gate_ff;
   logic             nxt_gate;
   logic [4:0]       dly_ff;
   logic [4:0]       nxt_dly;
   logic             cond_ff;
   logic             nxt_cond;
   logic             refo_ff;
   logic             nxt_refo;

   // Edge decode
   wire p_rise    = lnk.ref_clk_primary & ~p_q_ff;
   wire s_rise    = lnk.ref_clk_secondary & ~s_q_ff;
   wire p_fall    = ~lnk.ref_clk_primary & p_q_ff;
   wire s_fall    = ~lnk.ref_clk_secondary & s_q_ff;
   wire trig_rise = lnk.switch_trig & ~trig_q_ff;
   wire lock_fall = ~lnk.pll_locked & lock_q_ff;

   // Old and new clock views
   wire old_fall   = sel_ff ? s_fall : p_fall;
   wire new_fall   = sel_ff ? p_fall : s_fall;
   wire old_bad    = sel_ff ? bad1_ff : bad0_ff;
   wire new_bad    = sel_ff ? bad0_ff : bad1_ff;
   // Dead old clock cannot count, so the delay runs on the new one
   wire dly_tick   = old_bad ? new_fall : old_fall;

   // Causes of a switchover
   wire man_cause  = ~lnk.auto_en & (lnk.switch_trig != sel_ff);
   wire auto_cause = lnk.auto_en & (trig_rise | lock_fall | old_bad);

   // Counter step, saturating at the bad threshold
   wire [1:0] inc0 = (cnt0_ff == 2'(swo_pkg::EDGE_BAD_CNT)) ? cnt0_ff : cnt0_ff + 2'h1;
   wire [1:0] inc1 = (cnt1_ff == 2'(swo_pkg::EDGE_BAD_CNT)) ? cnt1_ff : cnt1_ff + 2'h1;
   wire [1:0] step0 = p_rise ? inc0 : cnt0_ff;
   wire [1:0] step1 = s_rise ? inc1 : cnt1_ff;
   wire       alt   = (step0 != 2'h0) & (step1 != 2'h0);
   wire       hit0  = (step0 == 2'(swo_pkg::EDGE_BAD_CNT));
   wire       hit1  = (step1 == 2'(swo_pkg::EDGE_BAD_CNT));

   always_comb begin
      nxt_cnt0 = alt ? 2'h0 : step0;
      nxt_cnt1 = alt ? 2'h0 : step1;
      // Set wins: a fresh miss is flagged even on an alternation cycle
      nxt_bad0 = lnk.auto_en & (hit1 | (bad0_ff & ~alt));
      nxt_bad1 = lnk.auto_en & (hit0 | (bad1_ff & ~alt));
   end

   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_sel   = sel_ff;
      nxt_gate  = gate_ff;
      nxt_dly   = dly_ff;
      nxt_cond  = cond_ff;
      unique case (state_ff)
         swo_pkg::SW_IDLE: begin
            if (man_cause | auto_cause) begin
               nxt_state = swo_pkg::SW_DELAY;
               nxt_dly   = lnk.delay_sel;
               nxt_cond  = lnk.auto_en;
            end
         end
         swo_pkg::SW_DELAY: begin
            if (dly_ff == 5'h00) begin
               nxt_state = swo_pkg::SW_GATE;
            end else if (dly_tick) begin
               nxt_dly = dly_ff - 5'h01;
            end
         end
         swo_pkg::SW_GATE: begin
            // Dead old clock has no falling edge left to wait for
            if (old_fall | old_bad) begin
               nxt_gate  = 1'b1;
               nxt_state = swo_pkg::SW_SWAP;
            end
         end
         swo_pkg::SW_SWAP: begin
            // Holds here while the target clock is missing
            if (new_fall & ~new_bad) begin
               nxt_sel   = ~sel_ff;
               nxt_gate  = 1'b0;
               nxt_state = swo_pkg::SW_IDLE;
               nxt_cond  = 1'b0;
            end
         end
      endcase
      if (!lnk.auto_en) begin
         nxt_cond = 1'b0;
      end
   end

   // Mux output, glitch-free through the gate
   always_comb begin
      nxt_refo = ~gate_ff & (sel_ff ? lnk.ref_clk_secondary : lnk.ref_clk_primary);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         p_q_ff    <= 1'b0;
         s_q_ff    <= 1'b0;
         trig_q_ff <= 1'b0;
         lock_q_ff <= 1'b0;
      end else begin
         p_q_ff    <= lnk.ref_clk_primary;
         s_q_ff    <= lnk.ref_clk_secondary;
         trig_q_ff <= lnk.switch_trig;
         lock_q_ff <= lnk.pll_locked;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         cnt0_ff <= 2'h0;
         cnt1_ff <= 2'h0;
         bad0_ff <= 1'b0;
         bad1_ff <= 1'b0;
      end else begin
         cnt0_ff <= nxt_cnt0;
         cnt1_ff <= nxt_cnt1;
         bad0_ff <= nxt_bad0;
         bad1_ff <= nxt_bad1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_ff <= swo_pkg::SW_IDLE;
         sel_ff   <= 1'b0;
         gate_ff  <= 1'b0;
         dly_ff   <= 5'h00;
         cond_ff  <= 1'b0;
         refo_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sel_ff   <= nxt_sel;
         gate_ff  <= nxt_gate;
         dly_ff   <= nxt_dly;
         cond_ff  <= nxt_cond;
         refo_ff  <= nxt_refo;
      end
   end

   // Outputs
   assign lnk.primary_bad_flag   = bad0_ff;
   assign lnk.secondary_bad_flag = bad1_ff;
   assign lnk.switch_cond        = cond_ff;
   // Selection still follows in manual mode; only the report is hidden
   assign lnk.active_clk         = lnk.auto_en & sel_ff;
   assign lnk.pll_ref_clk        = refo_ff;

endmodule : swo_device
`default_nettype wire

// file: rtl/swo_user.sv
`timescale 1ns/1ps
`default_nettype none
module swo_user (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   output logic             irq_o,
   // Link
   swo_if.user              lnk
);
   logic [31:0] ctrl_ff;
   logic [4:0]  irq_s_ff;
   logic [4:0]  irq_m_ff;
   logic [4:0]  prev_ff;
   logic [7:0]  trig_cnt_ff;
   logic        trig_ff;
   logic [1:0]  arst_cnt_ff;
   logic        pfd_ff;
   logic [4:0]  lock_cnt_ff;
   logic [31:0] nxt_rdata;

   wire [4:0] stat = {~lnk.pll_locked, lnk.active_clk, lnk.switch_cond,
                      lnk.secondary_bad_flag, lnk.primary_bad_flag};
   // Rising of status bits; activity change counts both ways
   wire [4:0] ev = {stat[4] & ~prev_ff[4], stat[3] ^ prev_ff[3],
                    stat[2:0] & ~prev_ff[2:0]};
   wire wr_ctrl = wr_i & (addr_i == swo_pkg::CTRL_OFS);
   wire wr_cmd  = wr_i & (addr_i == swo_pkg::CMD_OFS);
   wire wr_is   = wr_i & (addr_i == swo_pkg::IRQ_S_OFS);
   wire wr_im   = wr_i & (addr_i == swo_pkg::IRQ_M_OFS);
   wire sw_done = ev[swo_pkg::EV_ACT];
   wire any_bad = ev[swo_pkg::EV_BAD0] | ev[swo_pkg::EV_BAD1];
   wire in_sw   = trig_ff | lnk.switch_cond | (arst_cnt_ff != 2'h0);
   wire lock_ok = (lock_cnt_ff == 5'(swo_pkg::LOCK_STABLE_CYC));

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (rd_i) begin
         unique case (addr_i)
            swo_pkg::CTRL_OFS:  nxt_rdata = ctrl_ff;
            swo_pkg::STAT_OFS:  nxt_rdata = {27'h0, stat};
            swo_pkg::IRQ_S_OFS: nxt_rdata = {27'h0, irq_s_ff};
            swo_pkg::IRQ_M_OFS: nxt_rdata = {27'h0, irq_m_ff};
            default:            nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         ctrl_ff  <= swo_pkg::CTRL_RST;
         irq_s_ff <= 5'h00;
         irq_m_ff <= 5'h00;
         prev_ff  <= 5'h00;
         rdata_o  <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) ctrl_ff <= wdata_i;
         if (wr_im) irq_m_ff <= wdata_i[4:0];
         // Set wins over write-one-to-clear
         irq_s_ff <= ev | (irq_s_ff & ~(wr_is ? wdata_i[4:0] : 5'h00));
         prev_ff  <= stat;
         rdata_o  <= nxt_rdata;
      end
   end

   // Trigger held until the switch lands or a cap runs out
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         trig_ff     <= 1'b0;
         trig_cnt_ff <= 8'h00;
      end else if (wr_cmd & wdata_i[swo_pkg::CMD_TRIG] & ~trig_ff) begin
         trig_ff     <= 1'b1;
         trig_cnt_ff <= 8'(swo_pkg::TRIG_MAX_CYC);
      end else if (trig_ff & (sw_done | (trig_cnt_ff == 8'h00))) begin
         trig_ff <= 1'b0;
      end else if (trig_ff) begin
         trig_cnt_ff <= trig_cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         arst_cnt_ff <= 2'h0;
         pfd_ff      <= 1'b1;
         lock_cnt_ff <= 5'h00;
      end else begin
         if ((sw_done & ctrl_ff[swo_pkg::CTRL_RSTSW]) | (wr_cmd & wdata_i[swo_pkg::CMD_RST]))
            arst_cnt_ff <= 2'(swo_pkg::ARESET_CYC);
         else if (arst_cnt_ff != 2'h0)
            arst_cnt_ff <= arst_cnt_ff - 2'h1;
         if (any_bad & ctrl_ff[swo_pkg::CTRL_PFDH])
            pfd_ff <= 1'b0;
         else if (sw_done)
            pfd_ff <= 1'b1;
         if (in_sw | ~lnk.pll_locked)
            lock_cnt_ff <= 5'h00;
         else if (!lock_ok)
            lock_cnt_ff <= lock_cnt_ff + 5'h01;
      end
   end

   assign irq_o          = |(irq_s_ff & irq_m_ff);
   assign lnk.auto_en    = ctrl_ff[swo_pkg::CTRL_AUTO];
   // Manual mode uses the level, auto mode the held pulse
   assign lnk.switch_trig = ctrl_ff[swo_pkg::CTRL_AUTO] ? trig_ff : ctrl_ff[swo_pkg::CTRL_MSEL];
   assign lnk.delay_sel  = ctrl_ff[swo_pkg::CTRL_DLY_LO +: swo_pkg::DLY_W];
   assign lnk.pll_areset = (arst_cnt_ff != 2'h0);
   assign lnk.pfd_enable = pfd_ff;
   assign lnk.out_clk_en = lock_ok;

endmodule : swo_user
`default_nettype wire

// file: verification/swo_properties.sv
`timescale 1ns/1ps
`default_nettype none
module swo_properties (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Link
   input wire logic pll_locked,
   input wire logic switch_trig,
   input wire logic auto_en,
   input wire logic primary_bad_flag,
   input wire logic secondary_bad_flag,
   input wire logic switch_cond,
   input wire logic active_clk,
   input wire logic pll_ref_clk,
   input wire logic pll_areset,
   input wire logic out_clk_en
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Four cycles outlast any trigger synchroniser, so no start may follow
   sequence trig_steady;
      (auto_en && switch_trig && pll_locked && !switch_cond
       && !primary_bad_flag && !secondary_bad_flag)[*4];
   endsequence
   sequence auto_flip;
      auto_en && $past(auto_en) && $changed(active_clk);
   endsequence
   a_reset_idle: assert property (
      $rose(rst_b_i) |-> !active_clk && !switch_cond && !primary_bad_flag && !secondary_bad_flag)
      else $error("status not idle after reset");
   a_manual_quiet: assert property (
      (!auto_en)[*2] |-> !primary_bad_flag && !secondary_bad_flag && !switch_cond && !active_clk)
      else $error("status driven in manual mode");
   a_flip_gated: assert property (auto_flip |-> !$past(pll_ref_clk))
      else $error("mux moved while reference not gated");
   a_flip_cond: assert property (auto_flip |-> $past(switch_cond))
      else $error("switch without switch condition");
   a_bad_cond: assert property (
      $rose(primary_bad_flag) && auto_en && !active_clk |-> ##[0:4] switch_cond)
      else $error("active clock bad without switch condition");
   a_unlock_cond: assert property (
      $fell(pll_locked) && auto_en && !switch_cond |-> ##[1:4] switch_cond)
      else $error("lock loss did not start a switch");
   a_trig_edge: assert property (trig_steady |=> !switch_cond)
      else $error("steady trigger started a switch");
   a_areset_pulse: assert property ($rose(pll_areset) |=> !pll_areset)
      else $error("reset pulse longer than one cycle");
   a_outen_lock: assert property ((!pll_locked)[*3] |-> !out_clk_en)
      else $error("output clocks enabled without lock");
endmodule : swo_properties
`default_nettype wire

// file: verification/tb_pll_ref_clock_switchover.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pll_ref_clock_switchover;
   logic        sys_clk    = 1'b0;
   logic        rst_b      = 1'b0;
   logic [7:0]  addr       = 8'h00;
   logic [31:0] wdata      = 32'h0000_0000;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic        en_p       = 1'b1;
   logic        en_s       = 1'b1;
   logic [2:0]  pc         = 3'h0;
   logic [2:0]  sc         = 3'h0;
   int          err_total  = 0;
   int          compares   = 0;
   int          areset_cnt = 0;
   int          edges      = 0;
   int          n;
   swo_if swo_if_inst ();
   swo_device swo_device_inst (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .lnk(swo_if_inst.device));
   swo_user swo_user_inst (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .lnk(swo_if_inst.user));
   swo_properties swo_properties_inst (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
      .pll_locked(swo_if_inst.pll_locked), .switch_trig(swo_if_inst.switch_trig),
      .auto_en(swo_if_inst.auto_en), .primary_bad_flag(swo_if_inst.primary_bad_flag),
      .secondary_bad_flag(swo_if_inst.secondary_bad_flag), .switch_cond(swo_if_inst.switch_cond),
      .active_clk(swo_if_inst.active_clk), .pll_ref_clk(swo_if_inst.pll_ref_clk),
      .pll_areset(swo_if_inst.pll_areset), .out_clk_en(swo_if_inst.out_clk_en));
   always #20 sys_clk = ~sys_clk;
   // References at 1/8 and 1/10 of sys clock; a stopped one rests low
   always @(posedge sys_clk) begin
      pc <= (pc == 3'h3) ? 3'h0 : pc + 3'h1;
      sc <= (sc == 3'h4) ? 3'h0 : sc + 3'h1;
      // Reset gives both references a known low start, with one driver each
      if (!rst_b) begin
         swo_if_inst.ref_clk_primary   <= 1'b0;
         swo_if_inst.ref_clk_secondary <= 1'b0;
      end else begin
         if (pc == 3'h3) swo_if_inst.ref_clk_primary <= en_p & ~swo_if_inst.ref_clk_primary;
         if (sc == 3'h4) swo_if_inst.ref_clk_secondary <= en_s & ~swo_if_inst.ref_clk_secondary;
      end
      if (swo_if_inst.pll_areset === 1'b1) areset_cnt <= areset_cnt + 1;
      if (swo_if_inst.pll_ref_clk === 1'b1) edges <= edges + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
      @(posedge sys_clk);
   endtask : rd_reg
   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : idle
   // Counts cycles in n until the active clock reaches v
   task automatic wait_act(input logic v);
      n = 0;
      while (swo_if_inst.active_clk !== v && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 2000) begin
         chk({31'h0, swo_if_inst.active_clk}, {31'h0, v});
         stop_test();
      end
   endtask : wait_act
   initial begin
      swo_if_inst.pll_locked = 1'b1;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd_reg(swo_pkg::CTRL_OFS, swo_pkg::CTRL_RST);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0000);
      rd_reg(8'h20, 32'h0000_0000);
      wr_reg(swo_pkg::IRQ_M_OFS, 32'h0000_001f);
      wr_reg(swo_pkg::CTRL_OFS, 32'h0000_1f09);
      rd_reg(swo_pkg::CTRL_OFS, 32'h0000_1f09);
      wr_reg(swo_pkg::CMD_OFS, 32'h0000_0001);
      wait_act(1'b1);
      chk({31'h0, n > 240}, 32'h0000_0001);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0008);
      chk(areset_cnt, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      rd_reg(swo_pkg::IRQ_S_OFS, 32'h0000_000c);
      wr_reg(swo_pkg::IRQ_S_OFS, 32'h0000_000c);
      chk({31'h0, irq}, 32'h0000_0000);
      wr_reg(swo_pkg::IRQ_M_OFS, 32'h0000_0000);
      wr_reg(swo_pkg::CTRL_OFS, 32'h0000_0009);
      wr_reg(swo_pkg::CMD_OFS, 32'h0000_0001);
      wait_act(1'b0);
      chk({31'h0, n < 40}, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      rd_reg(swo_pkg::IRQ_S_OFS, 32'h0000_000c);
      wr_reg(swo_pkg::IRQ_S_OFS, 32'h0000_001f);
      wr_reg(swo_pkg::IRQ_M_OFS, 32'h0000_001f);
      en_p <= 1'b0;
      wait_act(1'b1);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0009);
      rd_reg(swo_pkg::IRQ_S_OFS, 32'h0000_000d);
      wr_reg(swo_pkg::IRQ_S_OFS, 32'h0000_001f);
      en_p <= 1'b1;
      idle(40);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0008);
      wr_reg(swo_pkg::CMD_OFS, 32'h0000_0001);
      wait_act(1'b0);
      wr_reg(swo_pkg::CTRL_OFS, 32'h0000_000d);
      en_s <= 1'b0;
      idle(60);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0002);
      chk({31'h0, swo_if_inst.pfd_enable}, 32'h0000_0000);
      en_s <= 1'b1;
      idle(40);
      swo_if_inst.pll_locked <= 1'b0;
      wait_act(1'b1);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0018);
      chk({31'h0, swo_if_inst.pfd_enable}, 32'h0000_0001);
      swo_if_inst.pll_locked <= 1'b1;
      n = 0;
      while (swo_if_inst.out_clk_en !== 1'b1 && n < 60) begin
         @(posedge sys_clk);
         n++;
      end
      chk({31'h0, swo_if_inst.out_clk_en}, 32'h0000_0001);
      if (n >= 60) begin
         stop_test();
      end
      // Manual mode: only the reference feed shows the selection
      wr_reg(swo_pkg::CTRL_OFS, 32'h0000_0000);
      idle(60);
      wr_reg(swo_pkg::CTRL_OFS, 32'h0000_0002);
      idle(60);
      en_p <= 1'b0;
      idle(40);
      rd_reg(swo_pkg::STAT_OFS, 32'h0000_0000);
      n = edges;
      idle(40);
      chk({31'h0, edges > n}, 32'h0000_0001);
      en_p <= 1'b1;
      wr_reg(swo_pkg::CTRL_OFS, 32'h0000_0000);
      idle(60);
      en_s <= 1'b0;
      n = edges;
      idle(40);
      chk({31'h0, edges > n}, 32'h0000_0001);
      stop_test();
   end
endmodule : tb_pll_ref_clock_switchover
`default_nettype wire
